// ---- include/encoder_pulse_divider_cfg.svh ----
// Purpose: constants for the encoder pulse divider
// Assumes: 12-position configuration switch, active-low positions
// Notes: positions counted from 1 (position one is bit 0)
`ifndef ENCODER_PULSE_DIVIDER_CFG_SVH
`define ENCODER_PULSE_DIVIDER_CFG_SVH
`define SW_WIDTH 12
`define SW_RESERVED_BIT 0
`define SW_IN_MODE_BIT 1
`define SW_OUT_MODE_BIT 2
`define SW_CLEAR_BIT 3
`define SW_FACTOR_LSB 4
`define SW_FACTOR_MSB 11
`define FACTOR_WIDTH 8
`define COUNT_WIDTH 9
`define FACTOR_ZERO_AS 9'h100
`define CODE_WIDTH 3
`define CLK_HZ 50000000
`define INC_MAX_HZ 100000
`define CODE_MAX_HZ 50000
`define INC_MIN_PERIOD_CYCLES (`CLK_HZ / `INC_MAX_HZ)
`define CODE_MIN_PERIOD_CYCLES (`CLK_HZ / `CODE_MAX_HZ)
`endif

// ---- include/encoder_pulse_divider_pkg.sv ----
// Purpose: types for the encoder pulse divider
// Assumes: nothing
// Notes: types only; numbers live in the cfg header
package encoder_pulse_divider_pkg;
   typedef enum logic [1:0] {
      out_quadrature,
      out_phase_flag,
      out_pulse_dir
   } out_mode_t;
endpackage

// ---- core/encoder_pulse_divider.sv ----
// Purpose: divides incremental encoder pulses and repeats them to the drive
// Assumes: ref_clk 50 MHz; all inputs asynchronous to ref_clk
// Notes: switch positions read ON as 0; commutation code is only synchronised
`timescale 1ns/1ps
`include "encoder_pulse_divider_cfg.svh"

module encoder_pulse_divider (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [`SW_WIDTH-1:0] divider_config_switch,
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic enc_z,
   input wire logic [`CODE_WIDTH-1:0] commutation_code,
   output logic out_a,
   output logic out_b,
   output logic out_z,
   output logic [`CODE_WIDTH-1:0] commutation_code_sync,
   output logic b_leads
);
   import encoder_pulse_divider_pkg::*;

   // ============================================================
   // synchronisers
   // each group passes two flip-flops; only the second stage is read by logic
   // switches reset to all zero, so the clear position reads held after reset

   // configuration switches
   logic [`SW_WIDTH-1:0] sw_1;
   logic [`SW_WIDTH-1:0] sw;
   logic [`SW_WIDTH-1:0] next_sw_1;
   logic [`SW_WIDTH-1:0] next_sw;

   always_comb begin
      next_sw_1 = divider_config_switch;
      next_sw = sw_1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         sw_1 <= '0;
         sw <= '0;
      end else begin
         sw_1 <= next_sw_1;
         sw <= next_sw;
      end
   end

   // phases and index, a in bit 2, b in bit 1, z in bit 0
   logic [2:0] phase_1;
   logic [2:0] phase_2;
   logic [2:0] next_phase_1;
   logic [2:0] next_phase_2;

   always_comb begin
      next_phase_1 = {enc_a, enc_b, enc_z};
      next_phase_2 = phase_1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         phase_1 <= '0;
         phase_2 <= '0;
      end else begin
         phase_1 <= next_phase_1;
         phase_2 <= next_phase_2;
      end
   end

   // commutation code, passed on as a level only
   logic [`CODE_WIDTH-1:0] code_1;
   logic [`CODE_WIDTH-1:0] code_s;
   logic [`CODE_WIDTH-1:0] next_code_1;
   logic [`CODE_WIDTH-1:0] next_code_s;

   always_comb begin
      next_code_1 = commutation_code;
      next_code_s = code_1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         code_1 <= '0;
         code_s <= '0;
      end else begin
         code_1 <= next_code_1;
         code_s <= next_code_s;
      end
   end

   logic a_s;
   logic b_s;
   logic z_s;
   assign a_s = phase_2[2];
   assign b_s = phase_2[1];
   assign z_s = phase_2[0];

   // ============================================================
   // switch decode
   // switch bits arrive with ON already as 0; position one never read
   logic in_mode;
   logic out_mode;
   logic clear_on;
   logic [`FACTOR_WIDTH-1:0] factor_field;
   logic [`COUNT_WIDTH-1:0] factor;
   out_mode_t mode;

   function automatic logic [`COUNT_WIDTH-1:0] decode_factor(input logic [`FACTOR_WIDTH-1:0] f);
      if (f == '0)
         decode_factor = `FACTOR_ZERO_AS;
      else
         decode_factor = {1'b0, f};
   endfunction

   assign in_mode = sw[`SW_IN_MODE_BIT];
   assign out_mode = sw[`SW_OUT_MODE_BIT];
   assign clear_on = ~sw[`SW_CLEAR_BIT];
   assign factor_field = sw[`SW_FACTOR_MSB:`SW_FACTOR_LSB];
   assign factor = decode_factor(factor_field);

   always_comb begin
      if (in_mode)
         mode = out_pulse_dir;
      else if (out_mode)
         mode = out_phase_flag;
      else
         mode = out_quadrature;
   end

   // ============================================================
   // edge detection and direction
   logic a_d;
   logic b_d;
   logic dir;
   logic next_a_d;
   logic next_b_d;
   logic next_dir;
   logic a_rise;
   logic b_rise;

   assign a_rise = a_s & ~a_d;
   assign b_rise = b_s & ~b_d;

   always_comb begin
      next_a_d = a_s;
      next_b_d = b_s;
      next_dir = dir;
      if (mode == out_pulse_dir)
         next_dir = b_s;
      else if (a_rise)
         next_dir = b_s; // A rising while B high means B leads
      else if (b_rise)
         next_dir = ~a_s;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         a_d <= 1'b0;
         b_d <= 1'b0;
         dir <= 1'b0;
      end else begin
         a_d <= next_a_d;
         b_d <= next_b_d;
         dir <= next_dir;
      end
   end

   // ============================================================
   // divider
   // counts rising edges of A; divided A is high for the first n/2 rises of every n
   logic [`COUNT_WIDTH-1:0] count;
   logic [`COUNT_WIDTH-1:0] next_count;
   logic div_a;
   logic next_div_a;
   logic [`COUNT_WIDTH-1:0] half;

   function automatic logic [`COUNT_WIDTH-1:0] wrap_inc(input logic [`COUNT_WIDTH-1:0] c,
                                                       input logic [`COUNT_WIDTH-1:0] n);
      if (c >= n - 9'h001)
         wrap_inc = '0;
      else
         wrap_inc = c + 9'h001;
   endfunction

   // level of a divided phase after the rise taken with count c
   function automatic logic first_half(input logic [`COUNT_WIDTH-1:0] c,
                                       input logic [`COUNT_WIDTH-1:0] h);
      first_half = (c < h);
   endfunction

   assign half = factor >> 1;

   always_comb begin
      next_count = count;
      next_div_a = div_a;
      if (clear_on) begin
         next_count = '0;
         next_div_a = 1'b0;
      end else if (factor == 9'h001) begin
         // division by one repeats the phase directly
         next_div_a = a_s;
      end else if (a_rise) begin
         next_count = wrap_inc(count, factor);
         next_div_a = first_half(count, half);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         count <= '0;
         div_a <= 1'b0;
      end else begin
         count <= next_count;
         div_a <= next_div_a;
      end
   end

   // ============================================================
   // divided B
   // B rises after its A rise when A leads: copy divided A
   // B rises before its A rise when B leads: take the level that A rise will give
   logic div_b;
   logic next_div_b;

   always_comb begin
      next_div_b = div_b;
      if (clear_on)
         next_div_b = 1'b0;
      else if (mode != out_quadrature)
         next_div_b = 1'b0;
      else if (factor == 9'h001)
         next_div_b = b_s;
      else if (b_rise && a_s)
         next_div_b = div_a;
      else if (b_rise)
         next_div_b = first_half(count, half);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         div_b <= 1'b0;
      end else begin
         div_b <= next_div_b;
      end
   end

   // ============================================================
   // output stage
   logic next_out_a;
   logic next_out_b;
   logic next_out_z;

   always_comb begin
      next_out_a = div_a;
      next_out_z = z_s;
      unique case (mode)
         out_quadrature: next_out_b = div_b;
         out_phase_flag: next_out_b = dir;
         out_pulse_dir: next_out_b = b_s;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         out_a <= 1'b0;
         out_b <= 1'b0;
         out_z <= 1'b0;
         commutation_code_sync <= '0;
         b_leads <= 1'b0;
      end else begin
         out_a <= next_out_a;
         out_b <= next_out_b;
         out_z <= next_out_z;
         commutation_code_sync <= code_s;
         b_leads <= dir;
      end
   end

endmodule // encoder_pulse_divider

// ---- sim/encoder_pulse_divider_checker.sv ----
// Purpose: port checks for the encoder pulse divider
// Assumes: settings change only while clear is held
// Notes: up[2] marks settled pipes after reset
`timescale 1ns/1ps
`include "encoder_pulse_divider_cfg.svh"
module encoder_pulse_divider_checker (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [`SW_WIDTH-1:0] divider_config_switch,
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic enc_z,
   input wire logic [`CODE_WIDTH-1:0] commutation_code,
   input wire logic out_a,
   input wire logic out_b,
   input wire logic out_z,
   input wire logic [`CODE_WIDTH-1:0] commutation_code_sync,
   input wire logic b_leads
);
   wire logic [`SW_WIDTH-1:0] sw = divider_config_switch;
   logic [2:0] up;
   logic [2:0] next_up;
   always_comb next_up = up[2] ? up : up + 3'h1;
   always_ff @(posedge ref_clk) up <= rst_b ? next_up : 3'h0;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // ==========
   // checks
   a_index_follow: assert property (up[2] |-> out_z == $past(enc_z,3)) else $error("index");
   a_code_sync: assert property (up[2] |-> commutation_code_sync == $past(commutation_code,3))
      else $error("code");
   a_clear_hold: assert property (up[2] && !sw[3] && !$past(sw[3],5) |-> !out_a) else $error("clear");
   a_dir_copy: assert property (up[2] && sw[1] && sw[3] && $past(sw[3],6) |-> out_b == $past(enc_b,3))
      else $error("direction");
   a_flag_dir: assert property (up[2] && $past(enc_a,4) && !$past(enc_a,5) |=> b_leads == $past(enc_b,5))
      else $error("flag");
   a_flag_out: assert property (up[2] && sw[3:1] == 3'h6 && $past(sw[3],6) && $stable(b_leads)
      |-> out_b == b_leads) else $error("flag out");
   a_div_one: assert property (up[2] && sw[11:3] == 9'h003 && $past(sw[3],6) && $past(enc_a,3) == $past(enc_a,6)
      |-> out_a == $past(enc_a,3)) else $error("factor one");
   a_rise_cause: assert property (up[2] && $rose(out_a) |-> $past(enc_a,3) && !$past(enc_a,7))
      else $error("rise");
   c_fall: cover property ($fell(out_a));
   c_lead: cover property ($rose(b_leads));
   c_index: cover property ($rose(out_z));
endmodule // encoder_pulse_divider_checker
bind encoder_pulse_divider encoder_pulse_divider_checker i_chk (.ref_clk, .rst_b, .divider_config_switch, .enc_a,
   .enc_b, .enc_z, .commutation_code, .out_a, .out_b, .out_z, .commutation_code_sync, .b_leads);

// ---- sim/encoder_shaft_model.sv ----
// Purpose: shaft encoder driving phases, index and code
// Assumes: quarter steps of 125 and 126 clocks in turn, 100 kHz at most
// Notes: lines change just after a rising edge
`timescale 1ns/1ps
`include "encoder_pulse_divider_cfg.svh"
module encoder_shaft_model (
   input wire logic ref_clk,
   output logic enc_a,
   output logic enc_b,
   output logic enc_z,
   output logic [`CODE_WIDTH-1:0] commutation_code
);
   initial {enc_a, enc_b, enc_z, commutation_code} = '0;
   task automatic go(input logic a, input logic b);
      @(posedge ref_clk);
      enc_a <= a;
      enc_b <= b;
      repeat (`INC_MIN_PERIOD_CYCLES / 4 - 1) @(posedge ref_clk);
   endtask
   // half period; pd gives pulse plus direction, bl puts B ahead
   task automatic half(input logic up, input logic pd, input logic bl);
      @(posedge ref_clk);
      enc_z <= up & 1'($urandom);
      if (up) commutation_code <= `CODE_WIDTH'($urandom);
      go(pd ? 1'h0 : up ^ bl, pd ? bl : !(up ^ bl));
      go(up, pd ? bl : up);
   endtask
endmodule // encoder_shaft_model

// ---- sim/encoder_pulse_divider_test.sv ----
// Purpose: self-checking bench for the encoder pulse divider
// Assumes: encoder model paces its lines
// Notes: reference counts A rises since the last clear
`timescale 1ns/1ps
`include "encoder_pulse_divider_cfg.svh"
module encoder_pulse_divider_test;
   logic ref_clk;
   logic rst_b;
   logic [`SW_WIDTH-1:0] sw;
   logic enc_a, enc_b, enc_z, out_a, out_b, out_z, b_leads, e;
   logic [`CODE_WIDTH-1:0] code;
   logic [`CODE_WIDTH-1:0] code_sync;
   logic [7:0] f;
   int n_fail, n_checks, n, k;
   initial begin
      ref_clk = 1'h0;
      forever #10 ref_clk = ~ref_clk;
   end
   encoder_shaft_model i_enc (.ref_clk(ref_clk), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .commutation_code(code));
   encoder_pulse_divider i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .divider_config_switch(sw), .enc_a(enc_a),
      .enc_b(enc_b), .enc_z(enc_z), .commutation_code(code), .out_a(out_a), .out_b(out_b), .out_z(out_z),
      .commutation_code_sync(code_sync), .b_leads(b_leads));
   task automatic check(input string what, input logic exp, input logic got);
      n_checks++;
      if (exp !== got) begin
         n_fail++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // settings change only while the counter is held clear
   task automatic setup(input logic pd, input logic ph);
      sw[3] <= 1'h0;
      repeat (8) @(posedge ref_clk);
      sw <= {f, 1'h0, ph, pd, 1'($urandom)};
      repeat (8) @(posedge ref_clk);
      sw[3] <= 1'h1;
      repeat (8) @(posedge ref_clk);
      n = (f == 8'h00) ? 256 : int'(f);
      k = 0;
   endtask
   task automatic spin(input int p, input logic bl);
      repeat (p) begin
         i_enc.half(1'h1, sw[1], bl);
         k++;
         e = (k - 1) % n < n / 2;
         check("out_a rise", n == 1 || e, out_a);
         if (sw[1] | sw[2]) check("out_b", bl, out_b);
         else check("out_b rise", n == 1 || e, out_b);
         check("b_leads", bl, b_leads);
         check("out_z", enc_z, out_z);
         check("code", 1'h1, code_sync == code);
         i_enc.half(1'h0, sw[1], bl);
         check("out_a fall", n > 1 && e, out_a);
         if (sw[1] | sw[2]) check("out_b held", bl, out_b);
         else check("out_b fall", n > 1 && e, out_b);
         check("out_z low", enc_z, out_z);
      end
   endtask
   initial begin
      sw = 12'h000;
      rst_b = 1'h0;
      n_fail = 0;
      n_checks = 0;
      void'($urandom(34394));
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'h1;
      for (int m = 0; m < 4; m++) begin
         f = (m == 0) ? 8'h01 : 8'($urandom_range(5, 2));
         setup(m == 3, (m == 2) | ((m == 3) & 1'($urandom)));
         spin(2 * n + 1, 1'h0);
         spin(n + 1, 1'h1);
         $display("test %0d done", m);
      end
      f = 8'h00;
      setup(1'h1, 1'h0);
      spin(130, 1'($urandom));
      $display("test 4 done");
      report_and_stop();
   end
endmodule // encoder_pulse_divider_test
